// ===== design/ocs_pkg.sv
// Constants shared by the setup command interpreter and its test bench
package ocs_pkg;
    // Packet types
    localparam logic [7:0] TYPE_REQ = 8'h50;
    localparam logic [7:0] TYPE_RSP = 8'h55;
    // Command codes
    localparam logic [7:0] OTP_WRITE_CMD = 8'h12;
    localparam logic [7:0] OTP_READ_CMD = 8'h13;
    localparam logic [7:0] DEBUG_AUTH_MODE_SET_CMD = 8'h14;
    localparam logic [7:0] DEBUG_AUTH_MODE_QUERY_CMD = 8'h15;
    localparam logic [7:0] DEBUG_AUTH_KEY_SET_CMD = 8'h16;
    localparam logic [7:0] SERIAL_BOOT_DISABLE_CMD = 8'h17;
    localparam logic [7:0] SERIAL_BOOT_QUERY_CMD = 8'h18;
    // Request payload lengths
    localparam logic [31:0] LEN_OTP_WRITE = 32'h0000_0006;
    localparam logic [31:0] LEN_OTP_READ = 32'h0000_0002;
    localparam logic [31:0] LEN_AUTH_SET = 32'h0000_0002;
    localparam logic [31:0] LEN_NONE = 32'h0000_0000;
    localparam logic [31:0] LEN_KEY_SET = 32'h0000_0012;
    localparam logic [31:0] LEN_BOOT_DIS = 32'h0000_0002;
    localparam logic [31:0] LEN_BOOT_DIS_MIN = 32'h0000_0001;
    // Response payload lengths
    localparam logic [7:0] PLEN_RESULT = 8'h01;
    localparam logic [7:0] PLEN_MODE = 8'h02;
    localparam logic [7:0] PLEN_OTP_READ = 8'h05;
    // Packet layout, byte offsets
    localparam logic [2:0] OFS_TYPE = 3'h0;
    localparam logic [2:0] OFS_CODE = 3'h1;
    localparam logic [2:0] OFS_LEN_LSB = 3'h4;
    localparam logic [2:0] OFS_LEN_MSB = 3'h7;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h09;
    localparam logic [4:0] OFS_KEY = 5'h02;
    localparam int PAY_BUF_BYTES = 18;
    localparam int KEY_BYTES = 16;
    // Field values and reset values
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_ERR = 8'h01;
    localparam logic [7:0] AUTH_TYPE_FIXED = 8'h00;
    localparam logic [7:0] BOOT_DISABLE_MODE = 8'h01;
    localparam logic [7:0] AUTH_MODE_RST = 8'h00;
    localparam logic [7:0] BOOT_MODE_RST = 8'h00;
    localparam int TX_FIFO_DEPTH = 32;
    // Interpreter states, Gray along the receive/execute/send path
    typedef enum logic [2:0] {
        ST_HDR = 3'b000,
        ST_PAY = 3'b001,
        ST_SUM = 3'b011,
        ST_EXEC = 3'b010,
        ST_TX = 3'b110
    } ocs_state_e;
endpackage

// ===== design/ocs_stream_if.sv
// Byte stream carrier between the interpreter and its FIFO
`timescale 1ns/100ps
interface ocs_stream_if #(parameter int WIDTH = 8) ();
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ===== design/ocs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ocs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    ocs_stream_if.snk wr,
    // Drain side
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // Full stalls the source; DEPTH must be a power of two for the wrap
    assign wr.ready = (count_ff != FULL_COUNT);
    assign rd_valid_out = (count_ff != '0);
    assign rd_data_out = mem_ff[rd_ptr_ff];
    assign push = wr.valid && wr.ready;
    assign pop = rd_valid_out && rd_ready_in;

    // Storage, no reset needed on the data words
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= wr.data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    // Never more than DEPTH words held
    fifo_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        count_ff <= FULL_COUNT)
        else $error("fifo count above depth");
endmodule

// ===== design/ocs_otp_setup_cmd.sv
// Request/response packet interpreter for the device setup service
`timescale 1ns/100ps
module ocs_otp_setup_cmd
    import ocs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Request byte stream
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    // Response byte stream
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // OTP access port
    output logic otp_req_out,
    output logic otp_write_out,
    output logic [15:0] otp_addr_out,
    output logic [31:0] otp_wdata_out,
    input wire logic otp_done_in,
    input wire logic otp_fail_in,
    input wire logic [31:0] otp_rdata_in,
    // Debug-port authentication and boot settings
    output logic [7:0] debug_auth_mode_out,
    output logic [127:0] debug_auth_key_out,
    output logic debug_auth_key_load_out,
    output logic serial_boot_disabled_out
);
    ocs_state_e state_ff, nxt_state;
    logic rx_ready_ff, sum_ok_ff, otp_busy_ff, exec_done_ff;
    logic rx_take, tx_push, tx_last, req_good;
    logic [2:0] hdr_idx_ff;
    logic [4:0] tx_idx_ff;
    logic [7:0] type_ff, code_ff, sum_ff, result_ff, plen_ff;
    logic [7:0] auth_mode_ff, boot_mode_ff, tx_sum_ff, tx_byte;
    logic [31:0] len_ff, cnt_ff, rdata_ff;
    logic [7:0] pay_ff [PAY_BUF_BYTES];
    ocs_stream_if #(.WIDTH(8)) tx_if ();

    // Field checks per command; unknown codes fail
    function automatic logic req_fields_ok(input logic [7:0] c,
        input logic [31:0] l, input logic [7:0] p0, input logic [7:0] p1);
        case (c)
            OTP_WRITE_CMD: return l == LEN_OTP_WRITE;
            OTP_READ_CMD: return l == LEN_OTP_READ;
            DEBUG_AUTH_MODE_SET_CMD:
                return l == LEN_AUTH_SET && p1 == AUTH_TYPE_FIXED;
            DEBUG_AUTH_MODE_QUERY_CMD: return l == LEN_NONE;
            DEBUG_AUTH_KEY_SET_CMD:
                return l == LEN_KEY_SET && p1 == AUTH_TYPE_FIXED;
            SERIAL_BOOT_DISABLE_CMD:
                return (l == LEN_BOOT_DIS || l == LEN_BOOT_DIS_MIN) &&
                    p0 == BOOT_DISABLE_MODE;
            SERIAL_BOOT_QUERY_CMD: return l == LEN_NONE;
            default: return 1'b0;
        endcase
    endfunction

    assign rx_take = rx_valid_in && rx_ready_ff;
    assign tx_push = tx_if.valid && tx_if.ready;
    // Checksum follows the payload, which starts at the result byte
    assign tx_last = (tx_idx_ff == OFS_RESULT + plen_ff[4:0]);
    assign req_good = sum_ok_ff && type_ff == TYPE_REQ &&
        req_fields_ok(code_ff, len_ff, pay_ff[0], pay_ff[1]);
    assign rx_ready_out = rx_ready_ff;
    assign otp_addr_out = {pay_ff[1], pay_ff[0]};
    assign otp_wdata_out = {pay_ff[5], pay_ff[4], pay_ff[3], pay_ff[2]};
    assign debug_auth_mode_out = auth_mode_ff;
    assign serial_boot_disabled_out = boot_mode_ff[0]; // Holds only 00 or 01

    // Next state: receive header, payload, checksum, execute, answer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_HDR: if (rx_take && hdr_idx_ff == OFS_LEN_MSB) begin
                nxt_state = ({rx_data_in, len_ff[23:0]} == '0) ?
                    ST_SUM : ST_PAY;
            end
            ST_PAY: if (rx_take && cnt_ff == len_ff - 32'h1) begin
                nxt_state = ST_SUM;
            end
            ST_SUM: if (rx_take) nxt_state = ST_EXEC;
            ST_EXEC: if (exec_done_ff) nxt_state = ST_TX;
            ST_TX: if (tx_push && tx_last) nxt_state = ST_HDR;
        endcase
    end

    // State and input ready; intake stops while a request is served
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_HDR;
            rx_ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rx_ready_ff <= (nxt_state == ST_HDR || nxt_state == ST_PAY ||
                nxt_state == ST_SUM);
        end
    end

    // Header, payload and running checksum capture
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hdr_idx_ff <= '0;
            type_ff <= 8'h00;
            code_ff <= 8'h00;
            len_ff <= '0;
            cnt_ff <= '0;
            sum_ff <= 8'h00;
            sum_ok_ff <= 1'b0;
            for (int i = 0; i < PAY_BUF_BYTES; i++) begin
                pay_ff[i] <= 8'h00;
            end
        end else if (rx_take) begin
            if (state_ff == ST_HDR) begin
                hdr_idx_ff <= hdr_idx_ff + 3'h1;
                cnt_ff <= '0;
                sum_ff <= (hdr_idx_ff == OFS_TYPE) ?
                    rx_data_in : sum_ff + rx_data_in;
                if (hdr_idx_ff == OFS_TYPE) type_ff <= rx_data_in;
                if (hdr_idx_ff == OFS_CODE) code_ff <= rx_data_in;
                if (hdr_idx_ff >= OFS_LEN_LSB) begin
                    len_ff[8*(hdr_idx_ff-OFS_LEN_LSB) +: 8] <= rx_data_in;
                end
            end else if (state_ff == ST_PAY) begin
                sum_ff <= sum_ff + rx_data_in;
                cnt_ff <= cnt_ff + 32'h1;
                // Bytes beyond the longest known payload are only summed
                if (cnt_ff < PAY_BUF_BYTES) begin
                    pay_ff[cnt_ff[4:0]] <= rx_data_in;
                end
            end else begin
                sum_ok_ff <= (sum_ff == rx_data_in);
            end
        end
    end

    // Execution: settings, OTP access, result and response length
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            otp_req_out <= 1'b0;
            otp_write_out <= 1'b0;
            otp_busy_ff <= 1'b0;
            exec_done_ff <= 1'b0;
            result_ff <= RES_OK;
            plen_ff <= PLEN_RESULT;
            rdata_ff <= '0;
            auth_mode_ff <= AUTH_MODE_RST;
            boot_mode_ff <= BOOT_MODE_RST;
            debug_auth_key_out <= '0;
            debug_auth_key_load_out <= 1'b0;
        end else begin
            otp_req_out <= 1'b0;
            debug_auth_key_load_out <= 1'b0;
            exec_done_ff <= 1'b0;
            if (state_ff == ST_EXEC && !exec_done_ff && !otp_busy_ff) begin
                plen_ff <= PLEN_RESULT;
                result_ff <= req_good ? RES_OK : RES_ERR;
                exec_done_ff <= 1'b1;
                if (code_ff == DEBUG_AUTH_MODE_QUERY_CMD ||
                    code_ff == SERIAL_BOOT_QUERY_CMD) begin
                    plen_ff <= PLEN_MODE;
                end
                if (req_good) begin
                    unique case (code_ff)
                        OTP_WRITE_CMD, OTP_READ_CMD: begin
                            // Hold the answer until the OTP completes
                            otp_req_out <= 1'b1;
                            otp_write_out <= (code_ff == OTP_WRITE_CMD);
                            otp_busy_ff <= 1'b1;
                            exec_done_ff <= 1'b0;
                        end
                        DEBUG_AUTH_MODE_SET_CMD: auth_mode_ff <= pay_ff[0];
                        DEBUG_AUTH_KEY_SET_CMD: begin
                            auth_mode_ff <= pay_ff[0];
                            for (int i = 0; i < KEY_BYTES; i++) begin
                                debug_auth_key_out[8*i +: 8] <=
                                    pay_ff[OFS_KEY + i];
                            end
                            debug_auth_key_load_out <= 1'b1;
                        end
                        SERIAL_BOOT_DISABLE_CMD: boot_mode_ff <= pay_ff[0];
                        default: ;
                    endcase
                end
            end else if (otp_busy_ff && otp_done_in) begin
                otp_busy_ff <= 1'b0;
                exec_done_ff <= 1'b1;
                result_ff <= otp_fail_in ? RES_ERR : RES_OK;
                rdata_ff <= otp_rdata_in;
                if (!otp_write_out && !otp_fail_in) begin
                    plen_ff <= PLEN_OTP_READ;
                end
            end
        end
    end

    // Response byte for the current index; data bytes little-endian
    always_comb begin
        tx_byte = 8'h00;
        if (tx_last) begin
            tx_byte = tx_sum_ff;
        end else if (tx_idx_ff == 5'(OFS_TYPE)) begin
            tx_byte = TYPE_RSP;
        end else if (tx_idx_ff == 5'(OFS_CODE)) begin
            tx_byte = code_ff;
        end else if (tx_idx_ff == 5'(OFS_LEN_LSB)) begin
            tx_byte = plen_ff;
        end else if (tx_idx_ff == OFS_RESULT) begin
            tx_byte = result_ff;
        end else if (tx_idx_ff >= OFS_DATA) begin
            if (code_ff == OTP_READ_CMD) begin
                tx_byte = rdata_ff[8*(tx_idx_ff-OFS_DATA) +: 8];
            end else if (code_ff == DEBUG_AUTH_MODE_QUERY_CMD) begin
                tx_byte = auth_mode_ff;
            end else begin
                tx_byte = boot_mode_ff;
            end
        end
    end

    assign tx_if.valid = (state_ff == ST_TX);
    assign tx_if.data = tx_byte;
    // Response index and running checksum
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_idx_ff <= '0;
            tx_sum_ff <= 8'h00;
        end else if (tx_push) begin
            tx_idx_ff <= tx_last ? 5'h00 : tx_idx_ff + 5'h01;
            tx_sum_ff <= tx_last ? 8'h00 : tx_sum_ff + tx_byte;
        end
    end

    // FIFO lets a slow link stall the sender without losing bytes
    ocs_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .wr(tx_if.snk),
        .rd_data_out(tx_data_out),
        .rd_valid_out(tx_valid_out),
        .rd_ready_in(tx_ready_in)
    );

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence push_at(logic [4:0] i);
        tx_push && tx_idx_ff == i;
    endsequence
    sequence otp_pending;
        otp_busy_ff && !otp_done_in;
    endsequence
    rsp_type_a: assert property (push_at(5'h00) |-> tx_byte == TYPE_RSP)
        else $error("response type byte wrong");
    rsp_code_a: assert property (push_at(5'h01) |-> tx_byte == code_ff)
        else $error("response code differs from request");
    rsp_len_a: assert property (push_at(5'h04) |->
        tx_byte == plen_ff && plen_ff >= PLEN_RESULT)
        else $error("response length byte wrong");
    rsp_sum_a: assert property (tx_push && tx_last |->
        tx_byte == tx_sum_ff ##1 tx_sum_ff == 8'h00)
        else $error("response checksum wrong");
    otp_wait_a: assert property (otp_pending |=> state_ff != ST_TX)
        else $error("response sent before OTP completed");
    otp_word_a: assert property (otp_req_out && otp_write_out |->
        code_ff == OTP_WRITE_CMD && len_ff == LEN_OTP_WRITE &&
        state_ff == ST_EXEC)
        else $error("OTP write without a good write request");
    one_rsp_a: assert property (state_ff == ST_SUM && rx_take |=>
        !rx_ready_ff [*2])
        else $error("intake open while serving request");
    auth_set_a: assert property (state_ff == ST_EXEC && !exec_done_ff &&
        !otp_busy_ff && req_good && code_ff == DEBUG_AUTH_MODE_SET_CMD
        |=> auth_mode_ff == $past(pay_ff[0]) ##1 state_ff == ST_TX)
        else $error("auth mode not stored before answer");
    query_a: assert property (push_at(5'h09) |-> tx_byte == auth_mode_ff ||
        code_ff != DEBUG_AUTH_MODE_QUERY_CMD)
        else $error("auth query mode byte wrong");
endmodule

// ===== bench/ocs_host_model.sv
// Host-side model: builds and sends requests, collects response bytes
`timescale 1ns/100ps
module ocs_host_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Request stream toward the device
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // Response stream from the device
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic stall_in
);
    logic [7:0] rsp_q[$];

    // Sink takes bytes unless the bench asks it to stall
    assign tx_ready_out = ~stall_in;

    // Idle request line shows no valid byte
    initial begin
        rx_data_out = 8'hA5;
        rx_valid_out = 1'b0;
    end

    // Keep every byte popped from the response stream
    always @(posedge clk_in) begin
        if (rst_n_in === 1'b1 && tx_valid_in === 1'b1 && tx_ready_out) begin
            rsp_q.push_back(tx_data_in);
        end
    end

    // Header, little-endian length, payload, then the byte sum
    function automatic void build(input logic [7:0] typ,
            input logic [7:0] code, input logic [7:0] pay[$],
            output logic [7:0] pkt[$]);
        logic [31:0] n;
        logic [7:0] sum;
        n = pay.size();
        pkt = {typ, code, 8'h00, 8'h00, n[7:0], n[15:8], n[23:16]};
        pkt.push_back(n[31:24]);
        pkt = {pkt, pay};
        sum = 8'h00;
        foreach (pkt[i]) sum += pkt[i];
        pkt.push_back(sum);
    endfunction

    // Each byte is held until an edge sees ready high
    task automatic send(input logic [7:0] pkt[$]);
        foreach (pkt[i]) begin
            rx_data_out = pkt[i];
            rx_valid_out = 1'b1;
            while (rx_ready_in !== 1'b1) begin
                @(posedge clk_in);
                #1;
            end
            @(posedge clk_in);
            #1;
        end
        // Inverse of the last byte, so a stale value never looks right
        rx_data_out = ~rx_data_out;
        rx_valid_out = 1'b0;
        // One idle edge, so back-to-back sends never glitch valid
        @(posedge clk_in);
        #1;
    endtask
endmodule

// ===== bench/ocs_otp_setup_cmd_test.sv
// Self-checking bench for the setup command interpreter
`timescale 1ns/100ps
module ocs_otp_setup_cmd_test;
    import ocs_pkg::*;
    typedef struct {
        logic [7:0] code;
        int n;
        logic [63:0] pay;
        logic [7:0] res;
        int dn;
        logic [31:0] dat;
    } ocs_row_s;
    logic sys_clk_in, rst_n_in, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data, auth_mode;
    logic otp_req, otp_write, otp_done, otp_fail, key_load, boot_dis;
    logic otp_fail_on, stall;
    logic [15:0] otp_addr;
    logic [31:0] otp_wdata, otp_rdata;
    logic [127:0] auth_key, kx;
    logic [31:0] otp_mem[logic [15:0]];
    logic [7:0] pay[$], ed[$], pk[$], ep[$];
    int n_fail = 0, cmp_count = 0, key_loads = 0;
    // Ordinary requests in order; later rows depend on earlier ones
    ocs_row_s rows[11] = '{
        '{8'h14, 2, 64'h0005, RES_OK, 0, 32'h0},
        '{8'h15, 0, 64'h0, RES_OK, 1, 32'h05},
        '{8'h14, 2, 64'h0107, RES_ERR, 0, 32'h0},
        '{8'h15, 0, 64'h0, RES_OK, 1, 32'h05},
        '{8'h18, 0, 64'h0, RES_OK, 1, 32'h00},
        '{8'h17, 2, 64'h0002, RES_ERR, 0, 32'h0},
        '{8'h17, 2, 64'h0001, RES_OK, 0, 32'h0},
        '{8'h18, 0, 64'h0, RES_OK, 1, 32'h01},
        '{8'h12, 6, 64'hCAFE_1234_0120, RES_OK, 0, 32'h0},
        '{8'h13, 2, 64'h0120, RES_OK, 4, 32'hCAFE_1234},
        '{8'h11, 0, 64'h0, RES_ERR, 0, 32'h0}
    };

    ocs_otp_setup_cmd dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
        .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
        .otp_req_out(otp_req), .otp_write_out(otp_write),
        .otp_addr_out(otp_addr), .otp_wdata_out(otp_wdata),
        .otp_done_in(otp_done), .otp_fail_in(otp_fail),
        .otp_rdata_in(otp_rdata), .debug_auth_mode_out(auth_mode),
        .debug_auth_key_out(auth_key), .debug_auth_key_load_out(key_load),
        .serial_boot_disabled_out(boot_dis));
    ocs_host_model host (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .stall_in(stall));

    // 20 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // OTP store answers late, so an early response would show
    always @(posedge sys_clk_in) begin
        if (otp_req === 1'b1) begin
            repeat (20) @(posedge sys_clk_in);
            #1;
            check(host.rsp_q.size(), 0);
            if (otp_write === 1'b1) otp_mem[otp_addr] = otp_wdata;
            otp_rdata = otp_mem.exists(otp_addr) ? otp_mem[otp_addr] : 32'h0;
            otp_fail = otp_fail_on;
            otp_done = 1'b1;
            @(posedge sys_clk_in);
            #1;
            otp_done = 1'b0;
            otp_rdata = ~otp_rdata;
        end
    end

    // Count key store pulses
    always @(posedge sys_clk_in) if (key_load === 1'b1) key_loads++;

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Send one request from pay, expect result plus ed in the answer
    task automatic run_req(input logic [7:0] typ, input logic [7:0] code,
            input logic [7:0] sum_err, input logic [7:0] res);
        logic [7:0] rp[$];
        int k;
        host.build(typ, code, pay, pk);
        pk[pk.size()-1] += sum_err;
        rp = {res};
        foreach (ed[i]) rp.push_back(ed[i]);
        host.build(TYPE_RSP, code, rp, ep);
        host.send(pk);
        k = 0;
        while (host.rsp_q.size() < ep.size() && k < 3000) begin
            @(posedge sys_clk_in);
            k++;
        end
        repeat (3) @(posedge sys_clk_in);
        #1;
        check(host.rsp_q.size(), ep.size());
        foreach (ep[i]) check(host.rsp_q[i], ep[i]);
        host.rsp_q.delete();
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_fail++;
        $display("Watchdog expired");
        summarize();
    end

    initial begin
        rst_n_in = 1'b0;
        stall = 1'b0;
        otp_fail_on = 1'b0;
        otp_done = 1'b0;
        otp_fail = 1'b0;
        otp_rdata = 32'h0;
        repeat (3) @(posedge sys_clk_in);
        #1;
        check({rx_ready, tx_valid, boot_dis}, 3'h0);
        check(auth_mode, AUTH_MODE_RST);
        check(auth_key, 128'h0);
        rst_n_in = 1'b1;
        foreach (rows[i]) begin
            pay.delete();
            ed.delete();
            for (int j = 0; j < rows[i].n; j++)
                pay.push_back(rows[i].pay[8*j+:8]);
            for (int j = 0; j < rows[i].dn; j++)
                ed.push_back(rows[i].dat[8*j+:8]);
            run_req(TYPE_REQ, rows[i].code, 8'h00, rows[i].res);
        end
        check(auth_mode, 8'h05);
        check(boot_dis, 1'b1);
        check({otp_addr, otp_wdata}, 48'h0120_CAFE_1234);
        check(otp_mem[16'h0120], 32'hCAFE_1234);
        // Corrupt checksum and wrong type must both be refused
        pay = {8'h09, 8'h00};
        ed.delete();
        run_req(TYPE_REQ, 8'h14, 8'h01, RES_ERR);
        run_req(8'h51, 8'h14, 8'h00, RES_ERR);
        check(auth_mode, 8'h05);
        // Key set with a sixteen byte key
        pay = {8'h03, 8'h00};
        for (int j = 0; j < 16; j++) begin
            pay.push_back(8'h10 + 8'(j));
            kx[8*j+:8] = 8'h10 + 8'(j);
        end
        run_req(TYPE_REQ, 8'h16, 8'h00, RES_OK);
        check(auth_key, kx);
        check({key_loads, auth_mode}, {32'd1, 8'h03});
        // Four queries against a stalled sink fill the FIFO and stall intake
        pay.delete();
        host.build(TYPE_RSP, 8'h15, '{RES_OK, 8'h03}, ep);
        host.build(TYPE_REQ, 8'h15, pay, pk);
        stall = 1'b1;
        fork
            repeat (4) host.send(pk);
            begin
                repeat (150) @(posedge sys_clk_in);
                #1;
                check({rx_ready, tx_valid}, 2'b01);
                check(host.rsp_q.size(), 0);
                stall = 1'b0;
            end
        join
        repeat (60) @(posedge sys_clk_in);
        #1;
        check(host.rsp_q.size(), 44);
        foreach (host.rsp_q[i]) check(host.rsp_q[i], ep[i % 11]);
        host.rsp_q.delete();
        // Failed OTP read answers with an error and no data
        otp_fail_on = 1'b1;
        pay = {8'h20, 8'h01};
        run_req(TYPE_REQ, 8'h13, 8'h00, RES_ERR);
        summarize();
    end
endmodule
